/* File: design/dpr_avmm_regs.sv */
// avalon-mm slave holding policy, clear and init values plus sticky status
`timescale 1ns/100ps
module dpr_avmm_regs #(
  parameter int CFG_W = 18
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [dpr_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dpr_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dpr_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [dpr_pkg::CTRL_W-1:0] ctrl,
  output logic [CFG_W-1:0] clr_a,
  output logic [CFG_W-1:0] clr_b,
  output logic [CFG_W-1:0] init_a,
  output logic [CFG_W-1:0] init_b,
  input wire logic [dpr_pkg::STAT_W-1:0] status_set
);
  logic [dpr_pkg::STAT_W-1:0] status;
  logic next_wait;
  logic [31:0] next_rdata;
  logic [dpr_pkg::CTRL_W-1:0] next_ctrl;
  logic [dpr_pkg::STAT_W-1:0] next_status;
  logic [CFG_W-1:0] next_clr_a, next_clr_b, next_init_a, next_init_b;
  logic [31:0] cur;
  logic [31:0] mrg;
  logic take;

  // one wait cycle per access; write and read both complete on the 2nd edge
  always_comb begin
    cur = 32'h0;
    if (avs_address == dpr_pkg::IDX_CTRL) begin
      cur = {{(32-dpr_pkg::CTRL_W){1'b0}}, ctrl};
    end else if (avs_address == dpr_pkg::IDX_STATUS) begin
      cur = {{(32-dpr_pkg::STAT_W){1'b0}}, status};
    end else if (avs_address == dpr_pkg::IDX_CLR_A) begin
      cur = {{(32-CFG_W){1'b0}}, clr_a};
    end else if (avs_address == dpr_pkg::IDX_CLR_B) begin
      cur = {{(32-CFG_W){1'b0}}, clr_b};
    end else if (avs_address == dpr_pkg::IDX_INIT_A) begin
      cur = {{(32-CFG_W){1'b0}}, init_a};
    end else if (avs_address == dpr_pkg::IDX_INIT_B) begin
      cur = {{(32-CFG_W){1'b0}}, init_b};
    end
    mrg = dpr_pkg::be_merge(cur, avs_writedata, avs_byteenable);
    take = avs_write & ~avs_waitrequest;
    next_wait = ~((avs_read | avs_write) & avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_rdata = cur; // unmapped words read as zero
    end
    next_ctrl = ctrl;
    next_clr_a = clr_a;
    next_clr_b = clr_b;
    next_init_a = init_a;
    next_init_b = init_b;
    next_status = status;
    if (take) begin
      if (avs_address == dpr_pkg::IDX_CTRL) begin
        next_ctrl = mrg[dpr_pkg::CTRL_W-1:0];
      end else if (avs_address == dpr_pkg::IDX_STATUS) begin
        if (avs_byteenable[0]) begin
          next_status = status & ~avs_writedata[dpr_pkg::STAT_W-1:0];
        end
      end else if (avs_address == dpr_pkg::IDX_CLR_A) begin
        next_clr_a = mrg[CFG_W-1:0];
      end else if (avs_address == dpr_pkg::IDX_CLR_B) begin
        next_clr_b = mrg[CFG_W-1:0];
      end else if (avs_address == dpr_pkg::IDX_INIT_A) begin
        next_init_a = mrg[CFG_W-1:0];
      end else if (avs_address == dpr_pkg::IDX_INIT_B) begin
        next_init_b = mrg[CFG_W-1:0];
      end
    end
    // a new event beats a write-one clear in the same cycle
    next_status = next_status | status_set;
  end

  // register stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl <= dpr_pkg::RST_CTRL;
      status <= dpr_pkg::RST_STATUS;
      clr_a <= dpr_pkg::RST_CFG[CFG_W-1:0];
      clr_b <= dpr_pkg::RST_CFG[CFG_W-1:0];
      init_a <= dpr_pkg::RST_CFG[CFG_W-1:0];
      init_b <= dpr_pkg::RST_CFG[CFG_W-1:0];
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
      ctrl <= next_ctrl;
      status <= next_status;
      clr_a <= next_clr_a;
      clr_b <= next_clr_b;
      init_a <= next_init_a;
      init_b <= next_init_b;
    end
  end
endmodule

/* File: design/dpr_port_op.sv */
// per-port operation decode: which way the output latch is loaded
`timescale 1ns/100ps
module dpr_port_op (
  input wire logic preset,
  input wire logic active,
  input wire logic sync_clear,
  input wire logic store,
  input wire logic [1:0] policy,
  output logic do_store,
  output logic load_clear,
  output logic load_new,
  output logic load_mem,
  output logic reading
);
  // preset blocks every operation so memory stays untouched
  always_comb begin
    do_store = 1'b0;
    load_clear = 1'b0;
    load_new = 1'b0;
    load_mem = 1'b0;
    reading = 1'b0;
    if (!preset && active) begin // [R2]
      do_store = store; // [R3] [R4]
      if (sync_clear) begin
        load_clear = 1'b1; // [R3]
      end else if (!store) begin
        load_mem = 1'b1; // [R5]
        reading = 1'b1;
      end else if (policy == dpr_pkg::WM_PASS_OLD) begin
        load_mem = 1'b1; // [R7]
      end else if (policy != dpr_pkg::WM_HOLD) begin
        load_new = 1'b1; // [R6]
      end
      // hold policy loads nothing, latch keeps its value [R8]
    end
  end
endmodule

/* File: design/dpr_ram_top.sv */
// dual-port ram with parity, per-port output latches and collision handling
`timescale 1ns/100ps
module dpr_ram_top #(
  parameter int ADDR_W = dpr_pkg::DEF_ADDR_W,
  parameter int DATA_W = dpr_pkg::DEF_DATA_W,
  parameter int PAR_W = dpr_pkg::DEF_PAR_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic global_output_preset,
  input wire logic a_active,
  input wire logic a_output_sync_clear,
  input wire logic a_store,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_write_data_in,
  input wire logic [PAR_W-1:0] a_write_parity_in,
  output logic [DATA_W-1:0] a_read_data_out,
  output logic [PAR_W-1:0] a_read_parity_out,
  output logic a_out_invalid,
  input wire logic b_active,
  input wire logic b_output_sync_clear,
  input wire logic b_store,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_write_data_in,
  input wire logic [PAR_W-1:0] b_write_parity_in,
  output logic [DATA_W-1:0] b_read_data_out,
  output logic [PAR_W-1:0] b_read_parity_out,
  output logic b_out_invalid,
  input wire logic [dpr_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dpr_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dpr_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int CFG_W = DATA_W + PAR_W;
  localparam int DEPTH = 1 << ADDR_W;

  // storage; contents survive reset and preset alike
  logic [DATA_W-1:0] data_mem [DEPTH];
  logic [PAR_W-1:0] par_mem [DEPTH];

  // software-visible configuration
  logic [dpr_pkg::CTRL_W-1:0] ctrl;
  logic [CFG_W-1:0] clr_a, clr_b, init_a, init_b;
  logic [dpr_pkg::STAT_W-1:0] status_set;

  // ports gathered into pairs so one loop serves both
  logic [ADDR_W-1:0] addr_v [2];
  logic [DATA_W-1:0] din_v [2];
  logic [PAR_W-1:0] pin_v [2];
  logic [DATA_W-1:0] old_d [2];
  logic [PAR_W-1:0] old_p [2];
  logic [CFG_W-1:0] clr_v [2];
  logic [CFG_W-1:0] init_v [2];
  logic [1:0] pol_v [2];
  logic act_v [2];
  logic sclr_v [2];
  logic st_v [2];

  // decoded operations per port
  logic do_store [2];
  logic load_clear [2];
  logic load_new [2];
  logic load_mem [2];
  logic reading [2];

  // output latch state and next values
  logic [DATA_W-1:0] dout [2];
  logic [PAR_W-1:0] pout [2];
  logic inv [2];
  logic [DATA_W-1:0] next_dout [2];
  logic [PAR_W-1:0] next_pout [2];
  logic next_inv [2];
  logic inv_ev [2];
  logic conflict;

  assign addr_v[0] = a_addr;
  assign addr_v[1] = b_addr;
  assign din_v[0] = a_write_data_in;
  assign din_v[1] = b_write_data_in;
  assign pin_v[0] = a_write_parity_in;
  assign pin_v[1] = b_write_parity_in;
  assign act_v[0] = a_active;
  assign act_v[1] = b_active;
  assign sclr_v[0] = a_output_sync_clear;
  assign sclr_v[1] = b_output_sync_clear;
  assign st_v[0] = a_store;
  assign st_v[1] = b_store;
  assign clr_v[0] = clr_a;
  assign clr_v[1] = clr_b;
  assign init_v[0] = init_a;
  assign init_v[1] = init_b;
  assign pol_v[0] = ctrl[dpr_pkg::POL_A_LSB +: 2];
  assign pol_v[1] = ctrl[dpr_pkg::POL_B_LSB +: 2];

  // asynchronous read of the prior contents, taken before this edge's write
  assign old_d[0] = data_mem[a_addr];
  assign old_d[1] = data_mem[b_addr];
  assign old_p[0] = par_mem[a_addr];
  assign old_p[1] = par_mem[b_addr];

  // bus slave and configuration store
  dpr_avmm_regs #(
    .CFG_W(CFG_W)
  ) u_regs (
    .core_clk(core_clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ctrl(ctrl),
    .clr_a(clr_a),
    .clr_b(clr_b),
    .init_a(init_a),
    .init_b(init_b),
    .status_set(status_set)
  );

  // one decoder per port, neither sees the other's controls
  for (genvar g = 0; g < 2; g++) begin : g_port
    dpr_port_op u_op (
      .preset(global_output_preset),
      .active(act_v[g]),
      .sync_clear(sclr_v[g]),
      .store(st_v[g]),
      .policy(pol_v[g]),
      .do_store(do_store[g]),
      .load_clear(load_clear[g]),
      .load_new(load_new[g]),
      .load_mem(load_mem[g]),
      .reading(reading[g])
    ); // [R11]
  end

  // output latch next values including cross-port collision effects
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_dout[i] = dout[i];
      next_pout[i] = pout[i];
      next_inv[i] = inv[i];
      inv_ev[i] = 1'b0;
      if (global_output_preset) begin
        next_dout[i] = init_v[i][DATA_W-1:0]; // [R1]
        next_pout[i] = init_v[i][CFG_W-1:DATA_W]; // [R1]
        next_inv[i] = 1'b0;
      end else if (load_clear[i]) begin
        next_dout[i] = clr_v[i][DATA_W-1:0]; // [R3]
        next_pout[i] = clr_v[i][CFG_W-1:DATA_W]; // [R3]
        next_inv[i] = 1'b0;
      end else if (load_new[i]) begin
        next_dout[i] = din_v[i]; // [R6]
        next_pout[i] = pin_v[i]; // [R6]
        next_inv[i] = 1'b0;
      end else if (load_mem[i]) begin
        next_dout[i] = old_d[i]; // [R5] [R7]
        next_pout[i] = old_p[i]; // [R5] [R7]
        next_inv[i] = 1'b0;
      end
      // the other port writing our read address this very edge
      if (reading[i] && do_store[1-i] && addr_v[0] == addr_v[1]) begin
        if (pol_v[1-i] != dpr_pkg::WM_PASS_OLD) begin
          next_inv[i] = 1'b1; // [R9]
          inv_ev[i] = 1'b1;
        end
        // pass-old: the prior word loaded above is valid as is [R10]
      end
    end
  end

  // same-address writes from both ports land port b's word; flagged only
  assign conflict = do_store[0] && do_store[1] && a_addr == b_addr; // [R12]
  assign status_set[dpr_pkg::STAT_INV_A] = inv_ev[0];
  assign status_set[dpr_pkg::STAT_INV_B] = inv_ev[1];
  assign status_set[dpr_pkg::STAT_CONFLICT] = conflict;

  // memory write; port b is applied last so it wins a clash
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (do_store[i]) begin
        data_mem[addr_v[i]] <= din_v[i]; // [R4] [R3]
        par_mem[addr_v[i]] <= pin_v[i]; // [R4]
      end
    end
  end

  // output latches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        dout[i] <= '0;
        pout[i] <= '0;
        inv[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        dout[i] <= next_dout[i];
        pout[i] <= next_pout[i];
        inv[i] <= next_inv[i];
      end
    end
  end

  assign a_read_data_out = dout[0];
  assign a_read_parity_out = pout[0];
  assign a_out_invalid = inv[0];
  assign b_read_data_out = dout[1];
  assign b_read_parity_out = pout[1];
  assign b_out_invalid = inv[1];

  // checks on the latch and memory behaviour
  AST_PRESET_INIT: assert property (@(posedge core_clk) disable iff (!nrst)
    global_output_preset |=> a_read_data_out == $past(init_a[DATA_W-1:0])
      && a_read_parity_out == $past(init_a[CFG_W-1:DATA_W])
      && !a_out_invalid) // [R1]
    else $error("preset did not load init value on port a");

  AST_PRESET_NO_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
    global_output_preset |=> data_mem[$past(a_addr)] == $past(old_d[0])) // [R1]
    else $error("memory changed during preset");

  AST_IDLE_HOLDS: assert property (@(posedge core_clk) disable iff (!nrst)
    !global_output_preset && !a_active |=> $stable(a_read_data_out)
      && $stable(a_read_parity_out)
      && (data_mem[$past(a_addr)] == $past(old_d[0])
        || $past(b_store && b_active) || !$past(a_store))) // [R2]
    else $error("inactive port a changed state");

  AST_SYNC_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    !global_output_preset && b_active && b_output_sync_clear
      |=> b_read_data_out == $past(clr_b[DATA_W-1:0])
      && b_read_parity_out == $past(clr_b[CFG_W-1:DATA_W])) // [R3]
    else $error("sync clear value not loaded on port b");

  AST_STORE_WRITES: assert property (@(posedge core_clk) disable iff (!nrst)
    do_store[0] && !(do_store[1] && a_addr == b_addr)
      |=> data_mem[$past(a_addr)] == $past(a_write_data_in)
      && par_mem[$past(a_addr)] == $past(a_write_parity_in)) // [R4]
    else $error("port a store did not reach memory");

  AST_READ_SHOWS: assert property (@(posedge core_clk) disable iff (!nrst)
    reading[0] |=> a_read_data_out == $past(old_d[0])
      && a_read_parity_out == $past(old_p[0])) // [R5]
    else $error("port a read returned wrong word");

  AST_PASS_NEW: assert property (@(posedge core_clk) disable iff (!nrst)
    load_new[1] |=> b_read_data_out == $past(b_write_data_in)
      && b_read_parity_out == $past(b_write_parity_in)) // [R6]
    else $error("pass-new write not shown on port b");

  AST_PASS_OLD: assert property (@(posedge core_clk) disable iff (!nrst)
    do_store[0] && !a_output_sync_clear && pol_v[0] == dpr_pkg::WM_PASS_OLD
      |=> a_read_data_out == $past(old_d[0])) // [R7]
    else $error("pass-old write did not show prior word");

  AST_HOLD_KEEPS: assert property (@(posedge core_clk) disable iff (!nrst)
    (do_store[0] && !a_output_sync_clear
      && pol_v[0] == dpr_pkg::WM_HOLD) [*2]
      |=> $stable(a_read_data_out) && $stable(a_read_parity_out)) // [R8]
    else $error("hold policy let port a output move");

  AST_COLLIDE_INV: assert property (@(posedge core_clk) disable iff (!nrst)
    reading[1] && do_store[0] && a_addr == b_addr
      && pol_v[0] != dpr_pkg::WM_PASS_OLD |=> b_out_invalid) // [R9]
    else $error("collision did not invalidate port b");

  AST_COLLIDE_OLD: assert property (@(posedge core_clk) disable iff (!nrst)
    reading[1] && do_store[0] && a_addr == b_addr
      && pol_v[0] == dpr_pkg::WM_PASS_OLD
      |=> !b_out_invalid && b_read_data_out == $past(old_d[1])) // [R10]
    else $error("pass-old collision gave wrong word on port b");

  AST_PORTS_APART: assert property (@(posedge core_clk) disable iff (!nrst)
    reading[1] && !a_active |=> b_read_data_out == $past(old_d[1])) // [R11]
    else $error("port b read disturbed by idle port a");
endmodule

/* File: inc/dpr_pkg.sv */
// shared constants, register map and helpers for the dual-port ram block
// Functional notes
// R1: while global_output_preset is high, outputs load the init value; memory untouched
// R2: an inactive port neither reads nor writes; latches and memory hold
// R3: active sync clear loads the clear value; a simultaneous store still writes
// R4: active store writes data and parity into the addressed location
// R5: active read without store or clear shows stored data and parity
// R6: pass-new policy shows the newly written word on the same port
// R7: pass-old policy shows the prior contents, then overwrites the location
// R8: hold policy keeps the same port outputs unchanged while writes continue
// R9: pass-new or hold write to the other port's read address invalidates it
// R10: pass-old write to the other port's read address shows prior contents
// R11: both ports operate independently, each on its own port timing; here both ports are clocked by the one core_clk
// R12: driving logic must not write one address from both ports at once
package dpr_pkg;
  // array geometry defaults: 1024 words of 16 data and 2 parity bits
  localparam int DEF_ADDR_W = 10;
  localparam int DEF_DATA_W = 16;
  localparam int DEF_PAR_W = 2;
  localparam int BUS_W = 32;
  localparam int BUS_AW = 3;

  // register word indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_CLR_A = 3'h2;
  localparam logic [2:0] IDX_CLR_B = 3'h3;
  localparam logic [2:0] IDX_INIT_A = 3'h4;
  localparam logic [2:0] IDX_INIT_B = 3'h5;

  // control and status field layout
  localparam int CTRL_W = 4;
  localparam int POL_A_LSB = 0;
  localparam int POL_B_LSB = 2;
  localparam int STAT_W = 3;
  localparam int STAT_INV_A = 0;
  localparam int STAT_INV_B = 1;
  localparam int STAT_CONFLICT = 2;

  // values after reset
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [31:0] RST_CFG = 32'h0;

  // store read policy codes; code 3 behaves as pass-new
  localparam logic [1:0] WM_PASS_NEW = 2'h0;
  localparam logic [1:0] WM_PASS_OLD = 2'h1;
  localparam logic [1:0] WM_HOLD = 2'h2;

  // byte-lane merge of a bus write into a register image
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

/* File: sim/dpr_user_model.sv */
// behavioural user logic driving one memory port
`timescale 1ns/100ps
module dpr_user_model #(
  parameter int AW = 10,
  parameter int DW = 16,
  parameter int PW = 2
) (
  output logic active,
  output logic sync_clear,
  output logic store,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] din,
  output logic [PW-1:0] pin
);
  // quiet port from time zero
  initial begin
    active = 1'b0;
    sync_clear = 1'b0;
    store = 1'b0;
    addr = '0;
    din = '0;
    pin = '0;
  end

  // one request per call, issued right after a rising edge
  // caller never stores one address from both ports at once
  task automatic drive(input logic [AW+DW+PW+2:0] op);
    active <= op[AW+DW+PW+2];
    sync_clear <= op[AW+DW+PW+1];
    store <= op[AW+DW+PW];
    addr <= op[DW+PW +: AW];
    if (op[AW+DW+PW]) begin
      din <= op[DW-1:0];
      pin <= op[DW +: PW];
    end else begin
      // unused write data toggles so a stale word never looks valid
      din <= ~din;
      pin <= ~pin;
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the dual-port ram and its register bus
`timescale 1ns/100ps
module tb_top;
  logic core_clk, nrst, global_output_preset;
  logic a_active, a_output_sync_clear, a_store, a_out_invalid;
  logic b_active, b_output_sync_clear, b_store, b_out_invalid;
  logic [9:0] a_addr, b_addr;
  logic [15:0] a_write_data_in, b_write_data_in, a_read_data_out;
  logic [15:0] b_read_data_out;
  logic [1:0] a_write_parity_in, b_write_parity_in;
  logic [1:0] a_read_parity_out, b_read_parity_out;
  logic [2:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  int failures, comparisons, seed;
  logic [31:0] exp_q[$], seen_q[$];
  logic [17:0] rm [1024];
  logic [9:0] ad [8];
  logic [17:0] w, w2, la, lb;

  dpr_ram_top uut (.core_clk(core_clk), .nrst(nrst),
    .global_output_preset(global_output_preset), .a_active(a_active),
    .a_output_sync_clear(a_output_sync_clear), .a_store(a_store),
    .a_addr(a_addr), .a_write_data_in(a_write_data_in),
    .a_write_parity_in(a_write_parity_in), .a_read_data_out(a_read_data_out),
    .a_read_parity_out(a_read_parity_out), .a_out_invalid(a_out_invalid),
    .b_active(b_active), .b_output_sync_clear(b_output_sync_clear),
    .b_store(b_store), .b_addr(b_addr), .b_write_data_in(b_write_data_in),
    .b_write_parity_in(b_write_parity_in), .b_read_data_out(b_read_data_out),
    .b_read_parity_out(b_read_parity_out), .b_out_invalid(b_out_invalid),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dpr_user_model ua (.active(a_active), .sync_clear(a_output_sync_clear),
    .store(a_store), .addr(a_addr), .din(a_write_data_in),
    .pin(a_write_parity_in));
  dpr_user_model ub (.active(b_active), .sync_clear(b_output_sync_clear),
    .store(b_store), .addr(b_addr), .din(b_write_data_in),
    .pin(b_write_parity_in));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // monitor: every observed result is matched to the oldest note
  initial begin
    forever begin
      wait (seen_q.size() > 0 && exp_q.size() > 0);
      check(seen_q.pop_front(), exp_q.pop_front());
    end
  end

  // bus master: hold the request until waitrequest is seen low
  task automatic av_xfer(input logic rd, input logic [2:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= ~rd;
    // sample at the rising edge; data and release belong to that same edge
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      failures++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'b0, a, d, q);
  endtask

  task automatic reg_chk(input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    av_xfer(1'b1, a, 32'h0, q);
    seen_q.push_back(q);
  endtask

  function automatic logic [30:0] mk(input logic a, input logic c,
      input logic s, input logic [9:0] ad_v, input logic [17:0] wd);
    return {a, c, s, ad_v, wd};
  endfunction

  function automatic logic [30:0] rd(input logic [9:0] ad_v);
    return mk(1'b1, 1'b0, 1'b0, ad_v, 18'h0);
  endfunction

  function automatic logic [30:0] wr(input logic [9:0] ad_v,
                                     input logic [17:0] wd);
    return mk(1'b1, 1'b0, 1'b1, ad_v, wd);
  endfunction

  // one port request each, then idle and look once settled
  task automatic step(input logic [30:0] oa, input logic [30:0] ob);
    @(posedge core_clk);
    ua.drive(oa);
    ub.drive(ob);
  endtask

  task automatic settle();
    @(posedge core_clk);
    ua.drive(31'h0);
    ub.drive(31'h0);
    global_output_preset <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic go(input logic [30:0] oa, input logic [30:0] ob);
    step(oa, ob);
    settle();
  endtask

  // expected words are {invalid, parity, data} per port
  task automatic pchk(input logic [18:0] ea, input logic [18:0] eb);
    exp_q.push_back({13'h0, ea});
    exp_q.push_back({13'h0, eb});
    seen_q.push_back({13'h0, a_out_invalid, a_read_parity_out,
                      a_read_data_out});
    seen_q.push_back({13'h0, b_out_invalid, b_read_parity_out,
                      b_read_data_out});
  endtask

  initial begin
    seed = 48862;
    failures = 0;
    comparisons = 0;
    nrst = 1'b0;
    global_output_preset = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, an unmapped index and bits beyond the fields
    for (int i = 0; i < 8; i++) reg_chk(3'(i), 32'h0);
    av_wr(dpr_pkg::IDX_CLR_A, 32'h0002abcd);
    av_wr(dpr_pkg::IDX_CLR_B, 32'h00011234);
    av_wr(dpr_pkg::IDX_INIT_A, 32'h0003c0de);
    av_wr(dpr_pkg::IDX_INIT_B, 32'h00005a5a);
    av_wr(3'h6, 32'hffffffff);
    reg_chk(3'h6, 32'h0);
    reg_chk(dpr_pkg::IDX_CLR_A, 32'h0002abcd);
    av_wr(dpr_pkg::IDX_CTRL, 32'hffffffff);
    reg_chk(dpr_pkg::IDX_CTRL, 32'hf);
    av_wr(dpr_pkg::IDX_CTRL, 32'h0);
    $display("test registers done");
    // both ports write at once, then read each other's words
    w = 18'($random(seed));
    for (int k = 0; k < 8; k++) ad[k] = w[9:0] + 10'(k * 37);
    for (int k = 0; k < 4; k++) begin
      w = 18'($random(seed));
      w2 = 18'($random(seed));
      go(wr(ad[k], w), wr(ad[k+4], w2));
      rm[ad[k]] = w;
      rm[ad[k+4]] = w2;
      pchk({1'b0, w}, {1'b0, w2});
    end
    for (int k = 0; k < 4; k++) begin
      go(rd(ad[k+4]), rd(ad[k]));
      pchk({1'b0, rm[ad[k+4]]}, {1'b0, rm[ad[k]]});
    end
    $display("test ports done");
    // preset beats a store; memory keeps its word
    @(posedge core_clk);
    global_output_preset <= 1'b1;
    ua.drive(wr(ad[0], ~rm[ad[0]]));
    settle();
    pchk({1'b0, 18'h3c0de}, {1'b0, 18'h05a5a});
    go(rd(ad[0]), 31'h0);
    pchk({1'b0, rm[ad[0]]}, {1'b0, 18'h05a5a});
    // inactive port neither writes nor loads its latch
    go(mk(1'b0, 1'b0, 1'b1, ad[1], ~rm[ad[1]]), 31'h0);
    pchk({1'b0, rm[ad[0]]}, {1'b0, 18'h05a5a});
    go(rd(ad[1]), 31'h0);
    pchk({1'b0, rm[ad[1]]}, {1'b0, 18'h05a5a});
    // sync clear, with and without a store on the same edge
    w = 18'($random(seed));
    go(mk(1'b1, 1'b1, 1'b1, ad[1], w), mk(1'b1, 1'b1, 1'b0, ad[5], 18'h0));
    rm[ad[1]] = w;
    pchk({1'b0, 18'h2abcd}, {1'b0, 18'h11234});
    go(31'h0, rd(ad[1]));
    pchk({1'b0, 18'h2abcd}, {1'b0, w});
    lb = w;
    $display("test preset clear done");
    // pass-old: prior word shows, then the new one is stored
    av_wr(dpr_pkg::IDX_CTRL, 32'h1);
    w = 18'($random(seed));
    go(wr(ad[2], w), 31'h0);
    pchk({1'b0, rm[ad[2]]}, {1'b0, lb});
    rm[ad[2]] = w;
    go(rd(ad[2]), 31'h0);
    pchk({1'b0, w}, {1'b0, lb});
    la = w;
    // hold: back-to-back stores leave the latch alone
    av_wr(dpr_pkg::IDX_CTRL, 32'h2);
    w = 18'($random(seed));
    w2 = 18'($random(seed));
    step(wr(ad[3], w), 31'h0);
    step(wr(ad[0], w2), 31'h0);
    settle();
    rm[ad[3]] = w;
    rm[ad[0]] = w2;
    pchk({1'b0, la}, {1'b0, lb});
    go(rd(ad[3]), 31'h0);
    pchk({1'b0, w}, {1'b0, lb});
    la = w;
    $display("test write policies done");
    // collisions: the writer's policy decides what the reader sees
    av_wr(dpr_pkg::IDX_CTRL, 32'h0);
    w = 18'($random(seed));
    go(wr(ad[0], w), rd(ad[0]));
    pchk({1'b0, w}, {1'b1, rm[ad[0]]});
    rm[ad[0]] = w;
    la = w;
    reg_chk(dpr_pkg::IDX_STATUS, 32'h2);
    av_wr(dpr_pkg::IDX_STATUS, 32'h7);
    reg_chk(dpr_pkg::IDX_STATUS, 32'h0);
    av_wr(dpr_pkg::IDX_CTRL, 32'h2);
    go(wr(ad[1], ~rm[ad[1]]), rd(ad[1]));
    pchk({1'b0, la}, {1'b1, rm[ad[1]]});
    rm[ad[1]] = ~rm[ad[1]];
    av_wr(dpr_pkg::IDX_CTRL, 32'h1);
    w = 18'($random(seed));
    go(wr(ad[2], w), rd(ad[2]));
    pchk({1'b0, rm[ad[2]]}, {1'b0, rm[ad[2]]});
    rm[ad[2]] = w;
    go(rd(ad[1]), rd(ad[2]));
    pchk({1'b0, rm[ad[1]]}, {1'b0, w});
    $display("test collisions done");
    @(posedge core_clk);
    if (exp_q.size() != 0) failures++;
    finish_test();
  end
endmodule
